// ### hdl/sce_pkg.sv
// Shared constants and carrier types for the smart-card ETU and guard-time logic
package sce_pkg;

	// Register addresses on the plain register port
	localparam int ADDR_W = 3;
	localparam logic [ADDR_W-1:0] ADDR_DATA = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_CLOCK_CONFIG = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_ETU_DIVIDER = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG_TWO = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_GUARD_TIME = 3'h5;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG_ONE = 3'h6;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h7;

	// Values after reset
	localparam logic [7:0] RST_REG = 8'h00;

	// Field positions in uart_config_one and clock_config_reg
	localparam int CFG1_PROT_T1 = 4;
	localparam int CFG1_TX_MODE = 3;
	localparam int CFG1_SESSION = 1;
	localparam int CFG1_DIRECT_CONVENTION = 0;
	localparam int CCR_SYNC_CLOCK_LEVEL = 3;

	// Prescaler choices
	localparam logic [5:0] PRESC_HI = 6'h20;
	localparam logic [5:0] PRESC_LO = 6'h1f;

	// Spans in tenths of an ETU, plus the guard base in whole ETUs and the full-guard code
	localparam logic [11:0] TENTHS_PER_ETU = 12'h00a;
	localparam logic [11:0] SESSION_END_TENTHS = 12'h069;
	localparam logic [11:0] GT_BASE_ETU = 12'h00c;
	localparam logic [7:0] GT_FULL = 8'hff;
	localparam logic [11:0] FULL_T1_REV1 = 12'h06e;
	localparam logic [11:0] FULL_T1_REV2 = 12'h06c;
	localparam logic [11:0] FULL_T0_REV1 = 12'h078;
	localparam logic [11:0] FULL_T0_REV2 = 12'h076;

	// Second configuration register layout
	typedef struct packed {
		logic ext_irq_wake_enable;
		logic char_irq_disable;
		logic unused;
		logic rx_wake_enable;
		logic sync_card_select;
		logic convention_manual_select;
		logic half_etu_select;
		logic prescaler_select;
	} sce_cfg2_t;

	// Events and data coming from the character engine
	typedef struct packed {
		logic char_done;
		logic init_char_valid;
		logic init_char_direct;
		logic status_flag;
		logic [7:0] rx_byte;
		logic io_out;
		logic io_oe_n;
	} sce_core_evt_t;

endpackage

// ### hdl/sce_etu_gen.sv
// ETU tick generator: prescaler followed by an auto-reload divider
`timescale 1ns/100ps
`default_nettype none
module sce_etu_gen import sce_pkg::*; (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	// Timing inputs
	input wire logic card_tick,
	input wire logic step2,
	input wire logic [5:0] presc_val,
	input wire logic [7:0] divider,
	// Tick out
	output logic etu_tick
);
	logic [6:0] acc_r;
	logic [6:0] acc_sum;
	logic [7:0] div_cnt_r;
	logic ptick;

	// Half mode advances the prescaler two steps per card clock
	always_comb begin
		acc_sum = acc_r + (step2 ? 7'h02 : 7'h01);
		ptick = card_tick && (acc_sum >= {1'b0, presc_val});
	end

	// Prescaler accumulator
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			acc_r <= 7'h00;
		end else if (ce && card_tick) begin
			acc_r <= ptick ? acc_sum - {1'b0, presc_val} : acc_sum;
		end
	end

	// Down-counter from the divider value to the reload point
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt_r <= 8'h00;
			etu_tick <= 1'b0;
		end else if (ce) begin
			etu_tick <= 1'b0;
			if (divider == 8'h00) begin
				div_cnt_r <= 8'h00;
			end else if (ptick) begin
				if (div_cnt_r <= 8'h01) begin
					div_cnt_r <= divider;
					etu_tick <= 1'b1;
				end else begin
					div_cnt_r <= div_cnt_r - 8'h01;
				end
			end
		end
	end
endmodule // sce_etu_gen
`default_nettype wire

// ### hdl/sce_span_timer.sv
// Measures a span given in tenths of an ETU, counted in card clocks
`timescale 1ns/100ps
`default_nettype none
module sce_span_timer import sce_pkg::*; (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	// Control
	input wire logic start,
	input wire logic card_tick,
	input wire logic step2,
	input wire logic [12:0] etu_clks,
	input wire logic [11:0] tenths,
	// Status
	output logic expired,
	output logic done
);
	logic [25:0] elapsed_r;
	logic [29:0] scaled;
	logic [29:0] target;

	// Elapsed clock steps (two per card clock in half mode) times ten against clocks per ETU times tenths
	always_comb begin
		scaled = 30'(elapsed_r) * 30'd10;
		target = 30'(etu_clks) * 30'(tenths);
	end

	// Count from start until the target is reached
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			elapsed_r <= 26'h0000000;
			expired <= 1'b1;
			done <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (start) begin
				elapsed_r <= 26'h0000000;
				expired <= 1'b0;
			end else if (!expired) begin
				if (scaled >= target) begin
					expired <= 1'b1;
					done <= 1'b1;
				end else if (card_tick) begin
					elapsed_r <= elapsed_r + (step2 ? 26'h0000002 : 26'h0000001);
				end
			end
		end
	end
endmodule // sce_span_timer
`default_nettype wire

// ### hdl/sce_card_timing.sv
// Configuration, ETU timing, guard time and wake logic of the card UART
//
// Functional notes
// - External interrupt wake enable: falling edge on that pin ends power-down.
// - Receive wake enable: falling edge on the receive line ends power-down.
// - A character starting during power-down loses its beginning.
// - Character interrupt disable suppresses interrupts at character completion.
// - Sync card mode bypasses UART; only data bit 0 reaches the I/O pin.
// - Sync card mode: card clock pin follows the sync clock level bit.
// - Manual select takes software convention; else detect from first session character.
// - Prescaler select picks 32 when set, 31 when clear.
// - One ETU lasts prescaler times divider card clocks.
// - Half ETU select halves the ETU length in card clocks.
// - Half ETU select does nothing when card clock is the crystal clock.
// - Transmission waits the guard ETU count before sending the character.
// - Guard FFh, protocol T=1: period 11 ETU, or 10.8 on second revision.
// - Guard FFh, protocol T=0: period 12 ETU, or 11.8 on second revision.
// - ETU divider is an 8-bit auto-reload down-counter of prescaler ticks.
// - Session start clears itself 10.5 ETU after the initial character.
// - Convention bit set means direct, written by hardware or software.
`timescale 1ns/100ps
`default_nettype none
module sce_card_timing import sce_pkg::*; #(
	parameter int REVISION = 1
) (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Card clock source
	input wire logic card_tick,
	input wire logic card_clk_gen,
	input wire logic card_clk_is_xtal,
	// Character engine
	input wire sce_core_evt_t core_evt,
	output logic etu_tick,
	output logic tx_start,
	output logic [7:0] tx_byte,
	output logic direct_convention_direct,
	output logic protocol_t1,
	output logic rx_enable,
	output logic char_irq,
	// Power control
	input wire logic pd_request,
	input wire logic ext_irq_pin_n,
	output logic power_down,
	output logic wake,
	// Card pins
	input wire logic io_in,
	output logic io_out,
	output logic io_oe_n,
	output logic card_clk
);
	// Elaboration check of the revision
	generate
		if (REVISION != 1 && REVISION != 2) begin : g_bad_rev
			$error("REVISION must be 1 or 2");
		end
	endgenerate

	sce_cfg2_t cfg2_r;
	logic [7:0] guard_r;
	logic [7:0] div_r;
	logic [7:0] ccr_r;
	logic [6:0] cfg1_r;
	logic ext_prev_r;
	logic rx_prev_r;
	logic tx_pend_r;
	logic [5:0] presc;
	logic half_eff;
	logic [12:0] etu_clks;
	logic [11:0] guard_tenths;
	logic guard_exp;
	logic ses_done;
	logic ses_start;
	logic wr_cfg1;
	logic wr_data;
	logic issue;
	logic wake_cond;
	logic [7:0] rdata_nxt;

	// Derived timing values
	always_comb begin
		presc = cfg2_r.prescaler_select ? PRESC_HI : PRESC_LO;
		half_eff = cfg2_r.half_etu_select && !card_clk_is_xtal;
		etu_clks = 13'(presc) * 13'(div_r);
		wr_cfg1 = wr && addr == ADDR_CONFIG_ONE;
		wr_data = wr && addr == ADDR_DATA;
		ses_start = core_evt.init_char_valid && cfg1_r[CFG1_SESSION];
		issue = tx_pend_r && guard_exp && !tx_start && !wr_data;
	end

	// Guard span from start of one character to start of the next
	always_comb begin
		if (guard_r == GT_FULL) begin
			if (cfg1_r[CFG1_PROT_T1]) begin
				guard_tenths = (REVISION == 2) ? FULL_T1_REV2 : FULL_T1_REV1;
			end else begin
				guard_tenths = (REVISION == 2) ? FULL_T0_REV2 : FULL_T0_REV1;
			end
		end else begin
			guard_tenths = 12'((GT_BASE_ETU + 12'(guard_r)) * TENTHS_PER_ETU);
		end
	end

	// ETU tick source
	sce_etu_gen u_etu (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.ce(ce),
		.card_tick(card_tick),
		.step2(half_eff),
		.presc_val(presc),
		.divider(div_r),
		.etu_tick(etu_tick)
	);

	// Guard time between transmitted characters
	sce_span_timer u_guard (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.ce(ce),
		.start(issue),
		.card_tick(card_tick),
		.step2(half_eff),
		.etu_clks(etu_clks),
		.tenths(guard_tenths),
		.expired(guard_exp),
		.done()
	);

	// Session end after the initial character
	sce_span_timer u_session (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.ce(ce),
		.start(ses_start),
		.card_tick(card_tick),
		.step2(half_eff),
		.etu_clks(etu_clks),
		.tenths(SESSION_END_TENTHS),
		.expired(),
		.done(ses_done)
	);

	// Plain configuration registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cfg2_r <= sce_cfg2_t'(RST_REG);
			guard_r <= RST_REG;
			div_r <= RST_REG;
			ccr_r <= RST_REG;
		end else if (ce && wr) begin
			case (addr)
				ADDR_CONFIG_TWO: begin
					cfg2_r <= sce_cfg2_t'(wdata & 8'hdf);
				end
				ADDR_GUARD_TIME: guard_r <= wdata;
				ADDR_ETU_DIVIDER: div_r <= wdata;
				ADDR_CLOCK_CONFIG: ccr_r <= wdata & 8'h3f;
				default: ;
			endcase
		end
	end

	// First configuration register with hardware session and convention updates
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cfg1_r <= RST_REG[6:0];
		end else if (ce) begin
			if (wr_cfg1) begin
				cfg1_r[6:1] <= wdata[6:1];
			end else if (ses_done) begin
				cfg1_r[CFG1_SESSION] <= 1'b0;
			end
			if (cfg2_r.convention_manual_select) begin
				if (wr_cfg1) begin
					cfg1_r[CFG1_DIRECT_CONVENTION] <= wdata[CFG1_DIRECT_CONVENTION];
				end
			end else if (ses_start) begin
				cfg1_r[CFG1_DIRECT_CONVENTION] <= core_evt.init_char_direct;
			end
		end
	end

	// Transmit hand-off held until the guard span has run out
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_pend_r <= 1'b0;
			tx_start <= 1'b0;
			tx_byte <= RST_REG;
		end else if (ce) begin
			tx_start <= issue;
			if (wr_data && !cfg2_r.sync_card_select && cfg1_r[CFG1_TX_MODE]) begin
				tx_pend_r <= 1'b1;
				tx_byte <= wdata;
			end else if (issue) begin
				tx_pend_r <= 1'b0;
			end
		end
	end

	// Power-down state and wake on falling edges
	always_comb begin
		wake_cond = (cfg2_r.ext_irq_wake_enable && ext_prev_r && !ext_irq_pin_n)
			|| (cfg2_r.rx_wake_enable && rx_prev_r && !io_in);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ext_prev_r <= 1'b1;
			rx_prev_r <= 1'b1;
			power_down <= 1'b0;
			wake <= 1'b0;
			rx_enable <= 1'b1;
		end else if (ce) begin
			ext_prev_r <= ext_irq_pin_n;
			rx_prev_r <= io_in;
			wake <= power_down && wake_cond;
			if (power_down && wake_cond) begin
				power_down <= 1'b0;
			end else if (pd_request) begin
				power_down <= 1'b1;
			end
			// Receiver re-arms only on an idle line after wake
			if (power_down || pd_request) begin
				rx_enable <= 1'b0;
			end else if (io_in) begin
				rx_enable <= 1'b1;
			end
		end
	end

	// Character interrupt gating and mirrored configuration
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			char_irq <= 1'b0;
			direct_convention_direct <= 1'b0;
			protocol_t1 <= 1'b0;
		end else if (ce) begin
			char_irq <= core_evt.char_done && !cfg2_r.char_irq_disable;
			direct_convention_direct <= cfg1_r[CFG1_DIRECT_CONVENTION];
			protocol_t1 <= cfg1_r[CFG1_PROT_T1];
		end
	end

	// Card pins: UART path or synchronous bypass
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			io_out <= 1'b0;
			io_oe_n <= 1'b1;
			card_clk <= 1'b0;
		end else if (ce) begin
			if (cfg2_r.sync_card_select) begin
				card_clk <= ccr_r[CCR_SYNC_CLOCK_LEVEL];
				io_out <= 1'b0;
				if (wr_data) begin
					io_oe_n <= wdata[0];
				end
			end else begin
				card_clk <= card_clk_gen;
				io_out <= core_evt.io_out;
				io_oe_n <= core_evt.io_oe_n;
			end
		end
	end

	// Read data mux
	always_comb begin
		case (addr)
			ADDR_DATA: begin
				rdata_nxt = cfg2_r.sync_card_select ? {7'h00, io_in} : core_evt.rx_byte;
			end
			ADDR_CLOCK_CONFIG: rdata_nxt = ccr_r;
			ADDR_ETU_DIVIDER: rdata_nxt = div_r;
			ADDR_CONFIG_TWO: rdata_nxt = cfg2_r;
			ADDR_GUARD_TIME: rdata_nxt = guard_r;
			ADDR_CONFIG_ONE: rdata_nxt = {1'b0, cfg1_r};
			ADDR_STATUS: rdata_nxt = {4'h0, tx_pend_r, guard_exp, power_down, core_evt.status_flag};
			default: rdata_nxt = 8'h00;
		endcase
	end

	// Read data stands in the cycle after the strobe only
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 8'h00;
		end else if (ce) begin
			rdata <= rd ? rdata_nxt : 8'h00;
		end
	end

	property p_ext_wake;
		@(posedge ref_clk) disable iff (!nrst)
		(ce && power_down && cfg2_r.ext_irq_wake_enable && ext_prev_r && !ext_irq_pin_n)
			|=> (wake && !power_down);
	endproperty
	a_ext_wake: assert property (p_ext_wake) else $error("ext pin wake missed");

	property p_rx_wake;
		@(posedge ref_clk) disable iff (!nrst)
		(ce && power_down && cfg2_r.rx_wake_enable && rx_prev_r && !io_in) |=> wake;
	endproperty
	a_rx_wake: assert property (p_rx_wake) else $error("receive wake missed");

	property p_rx_off_pd;
		@(posedge ref_clk) disable iff (!nrst)
		(ce && power_down) |=> !rx_enable;
	endproperty
	a_rx_off_pd: assert property (p_rx_off_pd) else $error("receiver live in power-down");

	property p_irq_mask;
		@(posedge ref_clk) disable iff (!nrst)
		(ce && cfg2_r.char_irq_disable) |=> !char_irq;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked char irq raised");

	property p_sync_io;
		@(posedge ref_clk) disable iff (!nrst)
		(ce && cfg2_r.sync_card_select && wr_data) |=> (io_oe_n == $past(wdata[0]) && !io_out);
	endproperty
	a_sync_io: assert property (p_sync_io) else $error("sync io bit wrong");

	property p_sync_clk;
		@(posedge ref_clk) disable iff (!nrst)
		(ce && cfg2_r.sync_card_select) |=> card_clk == $past(ccr_r[CCR_SYNC_CLOCK_LEVEL]);
	endproperty
	a_sync_clk: assert property (p_sync_clk) else $error("sync clock not followed");

	property p_manual_direct_convention;
		@(posedge ref_clk) disable iff (!nrst)
		(ce && cfg2_r.convention_manual_select && wr_cfg1)
			|=> ##1 direct_convention_direct == $past(wdata[0], 2);
	endproperty
	a_manual_direct_convention: assert property (p_manual_direct_convention) else $error("manual convention lost");

	property p_guard_wait;
		@(posedge ref_clk) disable iff (!nrst)
		$rose(tx_start) |-> $past(guard_exp);
	endproperty
	a_guard_wait: assert property (p_guard_wait) else $error("sent inside guard");

	property p_session_end;
		@(posedge ref_clk) disable iff (!nrst)
		(ce && ses_done && !wr_cfg1) |=> !cfg1_r[CFG1_SESSION];
	endproperty
	a_session_end: assert property (p_session_end) else $error("session bit stuck");

	property p_bit5_zero;
		@(posedge ref_clk) disable iff (!nrst)
		(ce && rd && addr == ADDR_CONFIG_TWO) |=> !rdata[5];
	endproperty
	a_bit5_zero: assert property (p_bit5_zero) else $error("unused bit reads one");

	property p_presc;
		@(posedge ref_clk) disable iff (!nrst)
		etu_clks == 13'(cfg2_r.prescaler_select ? 6'd32 : 6'd31) * 13'(div_r);
	endproperty
	a_presc: assert property (p_presc) else $error("ETU length wrong");
endmodule // sce_card_timing
`default_nettype wire

// ### verification/sce_card_model.sv
// Card model: open-drain I/O line with pull-up, card can pull it low
`timescale 1ns/100ps
`default_nettype none
module sce_card_model (
	// Device side of the card pins
	input wire logic io_out,
	input wire logic io_oe_n,
	input wire logic card_clk,
	// Resolved I/O line level
	output logic io_line
);
	logic card_low = 1'b0;
	// Low if either party pulls, else the pull-up wins
	assign io_line = !(card_low || (!io_oe_n && !io_out));
	// Card pulls the line low or lets it go
	task drive_low(input logic v);
		card_low <= v;
	endtask
endmodule // sce_card_model
`default_nettype wire

// ### verification/test_sce_card_timing.sv
// Self-checking bench for the card timing block
`timescale 1ns/100ps
`default_nettype none
module test_sce_card_timing import sce_pkg::*;;
	logic ref_clk, nrst, wr, rd, xtal, pd_req, ext_n, ce, clk_gen;
	logic [ADDR_W-1:0] addr;
	logic [7:0] wdata, rdata, tx_byte;
	sce_core_evt_t core;
	logic etu_tick, tx_start, direct_convention_direct, protocol_t1, rx_enable, char_irq;
	logic power_down, wake, io_out, io_oe_n, card_clk, io_line;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;

	// Block under test and the card beside it
	sce_card_timing #(.REVISION(1)) DUT (
		.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .card_tick(1'b1), .card_clk_gen(clk_gen),
		.card_clk_is_xtal(xtal), .core_evt(core), .etu_tick(etu_tick), .tx_start(tx_start),
		.tx_byte(tx_byte), .direct_convention_direct(direct_convention_direct), .protocol_t1(protocol_t1),
		.rx_enable(rx_enable), .char_irq(char_irq), .pd_request(pd_req),
		.ext_irq_pin_n(ext_n), .power_down(power_down), .wake(wake), .io_in(io_line),
		.io_out(io_out), .io_oe_n(io_oe_n), .card_clk(card_clk)
	);
	sce_card_model card (.io_out(io_out), .io_oe_n(io_oe_n), .card_clk(card_clk),
		.io_line(io_line));

	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			results();
		end
	end

	// Compare and count
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	// Verdict
	task results();
		$display("checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Register port cycles
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 chk(what, rdata, exp);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Register reset values, unused bit, unmapped address
	task automatic t_regs();
		rd_chk("gt reset", ADDR_GUARD_TIME, RST_REG);
		rd_chk("cfg2 reset", ADDR_CONFIG_TWO, RST_REG);
		wr_reg(ADDR_CONFIG_TWO, 8'hff);
		rd_chk("cfg2 bit5", ADDR_CONFIG_TWO, 8'hdf);
		wr_reg(ADDR_GUARD_TIME, 8'ha5);
		rd_chk("gt rw", ADDR_GUARD_TIME, 8'ha5);
		// Clock enable low: the write must be ignored
		@(posedge ref_clk);
		ce <= 1'b0;
		wr_reg(ADDR_GUARD_TIME, 8'h5a);
		ce <= 1'b1;
		rd_chk("ce freeze", ADDR_GUARD_TIME, 8'ha5);
		wr_reg(3'h4, 8'hff);
		rd_chk("unmapped", 3'h4, 8'h00);
		wr_reg(ADDR_CONFIG_TWO, 8'h00);
	endtask

	// One ETU length, second period measured
	task automatic etu_case(input logic [7:0] cfg2, input logic x, input logic [7:0] dv,
		input int exp);
		int n;
		int k;
		wr_reg(ADDR_ETU_DIVIDER, dv);
		wr_reg(ADDR_CONFIG_TWO, cfg2);
		xtal <= x;
		n = 0;
		repeat (2) begin
			n = 0;
			for (k = 0; k < 3000 && etu_tick !== 1'b1; k++) @(posedge ref_clk) #1;
			do begin
				@(posedge ref_clk) #1;
				n++;
			end while (etu_tick !== 1'b1 && n < 3000);
		end
		chk("etu length", n, exp);
	endtask
	task automatic t_etu();
		etu_case(8'h00, 1'b0, 8'h02, 62);
		etu_case(8'h01, 1'b0, 8'h02, 64);
		etu_case(8'h02, 1'b0, 8'h02, 31);
		etu_case(8'h02, 1'b1, 8'h02, 62);
		etu_case(8'h00, 1'b0, 8'h0c, 372);
		xtal <= 1'b0;
	endtask

	// Start-to-start spacing of two back-to-back characters
	task automatic guard_case(input logic [7:0] cfg1, input logic [7:0] gt, input int span);
		int n;
		wr_reg(ADDR_GUARD_TIME, gt);
		wr_reg(ADDR_CONFIG_ONE, cfg1);
		wr_reg(ADDR_DATA, 8'h3c);
		n = 0;
		while (tx_start !== 1'b1 && n < 5000) begin
			@(posedge ref_clk) #1;
			n++;
		end
		chk("first byte", tx_byte, 8'h3c);
		chk("protocol", protocol_t1, cfg1[4]);
		wr_reg(ADDR_DATA, 8'hc3);
		n = 2;
		while (tx_start !== 1'b1 && n < 5000) begin
			@(posedge ref_clk) #1;
			n++;
		end
		chk("guard span", n >= span - 1 && n <= span + 4, 1'b1);
		chk("second byte", tx_byte, 8'hc3);
	endtask
	task automatic t_guard();
		wr_reg(ADDR_CONFIG_TWO, 8'h00);
		wr_reg(ADDR_ETU_DIVIDER, 8'h01);
		guard_case(8'h08, 8'h02, 434);
		guard_case(8'h18, GT_FULL, 341);
		guard_case(8'h08, GT_FULL, 372);
		wr_reg(ADDR_CONFIG_ONE, 8'h00);
	endtask

	// Character completion interrupt, enabled or suppressed
	task automatic irq_case(input logic [7:0] cfg2, input logic exp);
		wr_reg(ADDR_CONFIG_TWO, cfg2);
		@(posedge ref_clk);
		core.char_done <= 1'b1;
		core.status_flag <= 1'b1;
		@(posedge ref_clk);
		core.char_done <= 1'b0;
		#1 chk("char irq", char_irq, exp);
		// Mirrored flag readable by polling once the guard span is over
		settle(400);
		rd_chk("mirrored flag", ADDR_STATUS, 8'h05);
	endtask

	// Falling edge on one wake source, with or without power-down
	task automatic wake_case(input logic [7:0] cfg2, input logic use_ext, input logic enter,
		input logic exp_wake, input logic exp_pd);
		int k;
		logic seen;
		wr_reg(ADDR_CONFIG_TWO, cfg2);
		if (enter) begin
			@(posedge ref_clk);
			pd_req <= 1'b1;
			@(posedge ref_clk);
			pd_req <= 1'b0;
			settle(1);
			chk("in power down", {power_down, rx_enable}, 2'b10);
		end
		@(posedge ref_clk);
		if (use_ext) begin
			ext_n <= 1'b0;
		end else begin
			card.drive_low(1'b1);
		end
		seen = 1'b0;
		for (k = 0; k < 4; k++) begin
			@(posedge ref_clk) #1;
			seen = seen | (wake === 1'b1);
		end
		chk("wake", seen, exp_wake);
		chk("power down after", power_down, exp_pd);
		@(posedge ref_clk);
		ext_n <= 1'b1;
		card.drive_low(1'b0);
		settle(3);
		chk("rx enable", rx_enable, !exp_pd);
	endtask
	task automatic t_power();
		wake_case(8'h80, 1'b1, 1'b0, 1'b0, 1'b0);
		wake_case(8'h80, 1'b1, 1'b1, 1'b1, 1'b0);
		wake_case(8'h10, 1'b1, 1'b1, 1'b0, 1'b1);
		wake_case(8'h10, 1'b0, 1'b0, 1'b1, 1'b0);
		wake_case(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
	endtask

	// Synchronous card bypass: clock level and bit 0 on the I/O line
	task automatic t_sync();
		wr_reg(ADDR_CONFIG_TWO, 8'h08);
		wr_reg(ADDR_CLOCK_CONFIG, 8'h08);
		settle(2);
		chk("sync clock high", card_clk, 1'b1);
		wr_reg(ADDR_CLOCK_CONFIG, 8'h00);
		settle(2);
		chk("sync clock low", card_clk, 1'b0);
		wr_reg(ADDR_DATA, 8'hfe);
		settle(2);
		chk("sync drive", {io_oe_n, io_out}, 2'b00);
		rd_chk("sync read low", ADDR_DATA, 8'h00);
		wr_reg(ADDR_DATA, 8'h01);
		settle(2);
		chk("sync release", io_oe_n, 1'b1);
		rd_chk("sync read high", ADDR_DATA, 8'h01);
		wr_reg(ADDR_CONFIG_TWO, 8'h00);
		// Back in UART mode the engine and generated clock reach the pins
		clk_gen <= 1'b1;
		core.io_out <= 1'b1;
		core.io_oe_n <= 1'b0;
		settle(2);
		chk("async pins", {card_clk, io_oe_n, io_out}, 3'b101);
		@(posedge ref_clk);
		clk_gen <= 1'b0;
		core.io_out <= 1'b0;
		core.io_oe_n <= 1'b1;
	endtask

	// Session end after 10.5 ETU, detected and manual convention
	task automatic t_direct_convention();
		wr_reg(ADDR_ETU_DIVIDER, 8'h01);
		wr_reg(ADDR_CONFIG_ONE, 8'h02);
		@(posedge ref_clk);
		core.init_char_valid <= 1'b1;
		core.init_char_direct <= 1'b1;
		@(posedge ref_clk);
		core.init_char_valid <= 1'b0;
		settle(300);
		rd_chk("session held", ADDR_CONFIG_ONE, 8'h03);
		settle(40);
		rd_chk("session cleared", ADDR_CONFIG_ONE, 8'h01);
		chk("detected direct", direct_convention_direct, 1'b1);
		wr_reg(ADDR_CONFIG_ONE, 8'h00);
		rd_chk("auto direct_convention kept", ADDR_CONFIG_ONE, 8'h01);
		wr_reg(ADDR_CONFIG_TWO, 8'h04);
		wr_reg(ADDR_CONFIG_ONE, 8'h00);
		settle(2);
		chk("manual inverse", direct_convention_direct, 1'b0);
		wr_reg(ADDR_CONFIG_TWO, 8'h00);
	endtask

	// Main sequence
	initial begin
		nrst = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = 8'h00;
		core = '0;
		core.io_oe_n = 1'b1;
		xtal = 1'b0;
		ce = 1'b1;
		clk_gen = 1'b0;
		pd_req = 1'b0;
		ext_n = 1'b1;
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		t_regs();
		t_etu();
		t_guard();
		irq_case(8'h00, 1'b1);
		irq_case(8'h40, 1'b0);
		t_power();
		t_sync();
		t_direct_convention();
		results();
	end
endmodule // test_sce_card_timing
`default_nettype wire
